// [core/sev_group.sv]
`timescale 1ns/1ns
module sev_group #(
   parameter int WIDTH = sev_pkg::GRP_W
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic init_i,
   input wire logic [WIDTH-1:0] init_en_i,
   input wire logic en_wr_i,
   input wire logic [WIDTH-1:0] en_data_i,
   input wire logic evt_rd_i,
   input wire logic [WIDTH-1:0] cond_i,
   output logic [WIDTH-1:0] cond_o,
   output logic [WIDTH-1:0] event_o,
   output logic [WIDTH-1:0] enable_o,
   output logic summary_o
);
   sev_pkg::sev_grp_type r_reg;
   sev_pkg::sev_grp_type r_next;
   logic [WIDTH-1:0] rise;

   always_comb
   begin
      r_next = r_reg;
      rise = cond_i & ~r_reg.cond;
      r_next.cond = cond_i;
      // Read clears, a new rise in the same cycle still lands
      r_next.event_bits = (evt_rd_i ? '0 : r_reg.event_bits) | rise;
      if (init_i)
      begin
         r_next.enable = init_en_i;
      end
      else if (en_wr_i)
      begin
         r_next.enable = en_data_i;
      end
      r_next.summary = |(r_next.event_bits & r_next.enable);
   end

   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         r_reg <= '0;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign cond_o = r_reg.cond;
   assign event_o = r_reg.event_bits;
   assign enable_o = r_reg.enable;
   assign summary_o = r_reg.summary;

   rise_sets_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (cond_i & ~r_reg.cond) != '0 |=> ((event_o & $past(cond_i & ~r_reg.cond)) == $past(cond_i & ~r_reg.cond)))
      else $error("rising condition did not set event");
   event_holds_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !evt_rd_i |=> ((event_o & $past(event_o)) == $past(event_o)))
      else $error("event bit dropped without read");
   read_clears_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      evt_rd_i && (cond_i & ~r_reg.cond) == '0 |=> event_o == '0)
      else $error("event read did not clear");
   summary_gate_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      summary_o == |(event_o & enable_o))
      else $error("group summary not gated by enable");
endmodule

// [core/sev_pkg.sv]
package sev_pkg;
   localparam int SB_W = 8;
   localparam int GRP_W = 16;
   localparam int DATA_W = 16;
   // Status byte bit positions
   localparam int SB_OPER = 7;
   localparam int SB_MSS = 6;
   localparam int SB_ESB = 5;
   localparam int SB_MAV = 4;
   localparam int SB_QUES = 3;
   localparam int SB_ERRQ = 2;
   localparam int SB_BUSY = 1;
   localparam int SB_FAULT = 0;
   // Standard event latch bit positions
   localparam int EL_PON = 7;
   localparam int EL_URQ = 6;
   localparam int EL_CME = 5;
   localparam int EL_EXE = 4;
   localparam int EL_DDE = 3;
   localparam int EL_QYE = 2;
   localparam int EL_RQC = 1;
   localparam int EL_OPC = 0;
   localparam logic [SB_W-1:0] MSS_MASK = 8'h40;
   localparam logic [DATA_W-1:0] OPC_DONE = 16'h0001;
   localparam logic [DATA_W-1:0] OPC_PENDING = 16'h0000;

   typedef enum logic [4:0] {
      CMD_NOP, CMD_CLS, CMD_ESE_WR, CMD_ESE_RD, CMD_EVL_RD, CMD_OPC, CMD_OPC_BLOCK,
      CMD_OPC_POLL, CMD_PSC_WR, CMD_PSC_RD, CMD_RST, CMD_SRE_WR, CMD_SRE_RD,
      CMD_SB_RD, CMD_WAI, CMD_OPER_COND_RD, CMD_OPER_EN_WR, CMD_OPER_EN_RD,
      CMD_OPER_EVT_RD, CMD_QUES_COND_RD, CMD_QUES_EN_WR, CMD_QUES_EN_RD, CMD_QUES_EVT_RD
   } sev_cmd_type;

   typedef enum {ST_INIT, ST_RUN, ST_OPCWAIT} sev_state_type;

   typedef struct packed {
      logic cmd_err;
      logic exec_err;
      logic dev_err;
      logic query_err;
      logic local_key;
   } sev_evt_type;

   typedef struct packed {
      logic mav;
      logic error_queue_pending;
      logic busy;
      logic fault;
   } sev_stat_type;

   typedef struct packed {
      logic psc;
      logic [SB_W-1:0] sre;
      logic [SB_W-1:0] ese;
      logic [GRP_W-1:0] oper_en;
      logic [GRP_W-1:0] ques_en;
   } sev_nv_type;

   typedef struct packed {
      logic [GRP_W-1:0] cond;
      logic [GRP_W-1:0] event_bits;
      logic [GRP_W-1:0] enable;
      logic summary;
   } sev_grp_type;
endpackage

// [core/sev_status.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - Nonwaiting completion poll answers at once
// - Power-on clear setting decides mask clearing
// - Reset selects manual mode, clears transients
// - Service request mask write, nonvolatile copy
// - Service request mask read then clear
// - Status byte read then clear
// - Wait holds commands until pending done
// - Clear status zeroes byte and latch
// - Bits 7,5,3 are group summaries
// - Bits 4,2,1,0 show device status
// - Bit 6 master summary and service request
// - Mask bit 6 ignored, summary unmaskable
// - Event latch read then clear
// - Unmasked latch bit sets event summary
// - Latch bits 5,4,3,2 error kinds
// - Latch bits 7,6,0 power, key, complete
// - Event enable mask gates latch summary
// - Condition going true sets event bit
// - Enabled event bits form group summary
// - Group event read then clear
// - Group registers are sixteen bits
// - Completion command sets bit 0 later
module sev_status (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic cmd_valid_i,
   input wire sev_pkg::sev_cmd_type cmd_code_i,
   input wire logic [sev_pkg::DATA_W-1:0] cmd_data_i,
   input wire sev_pkg::sev_evt_type evt_i,
   input wire sev_pkg::sev_stat_type stat_i,
   input wire logic pending_ops_i,
   input wire logic [sev_pkg::GRP_W-1:0] oper_cond_i,
   input wire logic [sev_pkg::GRP_W-1:0] ques_cond_i,
   input wire sev_pkg::sev_nv_type nv_i,
   output logic cmd_ready_o,
   output logic resp_valid_o,
   output logic [sev_pkg::DATA_W-1:0] resp_data_o,
   output logic srq_o,
   output logic manual_mode_o,
   output logic transient_clear_o,
   output sev_pkg::sev_nv_type nv_o
);
   typedef struct packed {
      sev_pkg::sev_state_type st;
      logic ready;
      logic hold;
      logic opc_armed;
      logic psc;
      logic [sev_pkg::SB_W-1:0] sre;
      logic [sev_pkg::SB_W-1:0] ese;
      logic [sev_pkg::SB_W-1:0] evl;
      logic [sev_pkg::SB_W-1:0] sbyte;
      logic srq;
      logic resp_valid;
      logic [sev_pkg::DATA_W-1:0] resp_data;
      logic manual;
      logic tclear;
   } sev_main_type;

   sev_main_type r_reg;
   sev_main_type r_next;
   logic take;
   logic grp_init;
   logic oper_we;
   logic ques_we;
   logic oper_rd;
   logic ques_rd;
   logic sbyte_clr;
   logic evl_clr;
   logic opc_set;
   logic [sev_pkg::SB_W-1:0] evl_set;
   logic [sev_pkg::SB_W-1:0] sbyte_set;
   logic [sev_pkg::SB_W-1:0] sbyte_view;
   logic mss;
   logic esb;
   logic [sev_pkg::GRP_W-1:0] oper_cond, oper_evt, oper_en;
   logic [sev_pkg::GRP_W-1:0] ques_cond, ques_evt, ques_en;
   logic oper_sum;
   logic ques_sum;

   // Sixteen-bit operation and questionable groups
   sev_group #(.WIDTH(sev_pkg::GRP_W)) u_oper (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .init_i(grp_init),
      .init_en_i(nv_i.psc ? '0 : nv_i.oper_en),
      .en_wr_i(oper_we),
      .en_data_i(cmd_data_i),
      .evt_rd_i(oper_rd),
      .cond_i(oper_cond_i),
      .cond_o(oper_cond),
      .event_o(oper_evt),
      .enable_o(oper_en),
      .summary_o(oper_sum)
   );

   sev_group #(.WIDTH(sev_pkg::GRP_W)) u_ques (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .init_i(grp_init),
      .init_en_i(nv_i.psc ? '0 : nv_i.ques_en),
      .en_wr_i(ques_we),
      .en_data_i(cmd_data_i),
      .evt_rd_i(ques_rd),
      .cond_i(ques_cond_i),
      .cond_o(ques_cond),
      .event_o(ques_evt),
      .enable_o(ques_en),
      .summary_o(ques_sum)
   );

   always_comb
   begin
      r_next = r_reg;
      r_next.resp_valid = 1'b0;
      r_next.manual = 1'b0;
      r_next.tclear = 1'b0;
      take = cmd_valid_i & r_reg.ready;
      grp_init = 1'b0;
      oper_we = 1'b0;
      ques_we = 1'b0;
      oper_rd = 1'b0;
      ques_rd = 1'b0;
      sbyte_clr = 1'b0;
      evl_clr = 1'b0;
      opc_set = 1'b0;
      // Bit 6 is never masked and not part of its own summary
      mss = |(r_reg.sbyte & r_reg.sre & ~sev_pkg::MSS_MASK);
      sbyte_view = r_reg.sbyte;
      sbyte_view[sev_pkg::SB_MSS] = mss;
      esb = |(r_reg.evl & r_reg.ese);
      case (r_reg.st)
         sev_pkg::ST_INIT:
         begin
            r_next.psc = nv_i.psc;
            r_next.sre = nv_i.psc ? '0 : nv_i.sre;
            r_next.ese = nv_i.psc ? '0 : nv_i.ese;
            grp_init = 1'b1;
            r_next.st = sev_pkg::ST_RUN;
         end
         sev_pkg::ST_RUN:
         begin
            if (take)
            begin
               case (cmd_code_i)
                  sev_pkg::CMD_CLS:
                  begin
                     sbyte_clr = 1'b1;
                     evl_clr = 1'b1;
                     oper_rd = 1'b1;
                     ques_rd = 1'b1;
                  end
                  sev_pkg::CMD_ESE_WR: r_next.ese = cmd_data_i[sev_pkg::SB_W-1:0];
                  sev_pkg::CMD_ESE_RD:
                  begin
                     r_next.resp_valid = 1'b1;
                     r_next.resp_data = {8'h00, r_reg.ese};
                  end
                  sev_pkg::CMD_EVL_RD:
                  begin
                     r_next.resp_valid = 1'b1;
                     r_next.resp_data = {8'h00, r_reg.evl};
                     evl_clr = 1'b1;
                  end
                  sev_pkg::CMD_OPC:
                  begin
                     if (pending_ops_i)
                     begin
                        r_next.opc_armed = 1'b1;
                     end
                     else
                     begin
                        opc_set = 1'b1;
                     end
                  end
                  sev_pkg::CMD_OPC_BLOCK: r_next.st = sev_pkg::ST_OPCWAIT;
                  sev_pkg::CMD_OPC_POLL:
                  begin
                     r_next.resp_valid = 1'b1;
                     r_next.resp_data = pending_ops_i ? sev_pkg::OPC_PENDING
                                                      : sev_pkg::OPC_DONE;
                  end
                  sev_pkg::CMD_PSC_WR: r_next.psc = cmd_data_i[0];
                  sev_pkg::CMD_PSC_RD:
                  begin
                     r_next.resp_valid = 1'b1;
                     r_next.resp_data = {15'h0000, r_reg.psc};
                  end
                  sev_pkg::CMD_RST:
                  begin
                     r_next.manual = 1'b1;
                     r_next.tclear = 1'b1;
                     r_next.opc_armed = 1'b0;
                  end
                  sev_pkg::CMD_SRE_WR: r_next.sre = cmd_data_i[sev_pkg::SB_W-1:0];
                  sev_pkg::CMD_SRE_RD:
                  begin
                     r_next.resp_valid = 1'b1;
                     r_next.resp_data = {8'h00, r_reg.sre};
                     r_next.sre = '0;
                  end
                  sev_pkg::CMD_SB_RD:
                  begin
                     r_next.resp_valid = 1'b1;
                     r_next.resp_data = {8'h00, sbyte_view};
                     sbyte_clr = 1'b1;
                  end
                  sev_pkg::CMD_WAI: r_next.hold = pending_ops_i;
                  sev_pkg::CMD_OPER_COND_RD:
                  begin
                     r_next.resp_valid = 1'b1;
                     r_next.resp_data = oper_cond;
                  end
                  sev_pkg::CMD_OPER_EN_WR: oper_we = 1'b1;
                  sev_pkg::CMD_OPER_EN_RD:
                  begin
                     r_next.resp_valid = 1'b1;
                     r_next.resp_data = oper_en;
                  end
                  sev_pkg::CMD_OPER_EVT_RD:
                  begin
                     r_next.resp_valid = 1'b1;
                     r_next.resp_data = oper_evt;
                     oper_rd = 1'b1;
                  end
                  sev_pkg::CMD_QUES_COND_RD:
                  begin
                     r_next.resp_valid = 1'b1;
                     r_next.resp_data = ques_cond;
                  end
                  sev_pkg::CMD_QUES_EN_WR: ques_we = 1'b1;
                  sev_pkg::CMD_QUES_EN_RD:
                  begin
                     r_next.resp_valid = 1'b1;
                     r_next.resp_data = ques_en;
                  end
                  sev_pkg::CMD_QUES_EVT_RD:
                  begin
                     r_next.resp_valid = 1'b1;
                     r_next.resp_data = ques_evt;
                     ques_rd = 1'b1;
                  end
                  default: r_next.resp_valid = 1'b0;
               endcase
            end
         end
         sev_pkg::ST_OPCWAIT:
         begin
            if (!pending_ops_i)
            begin
               r_next.resp_valid = 1'b1;
               r_next.resp_data = sev_pkg::OPC_DONE;
               r_next.st = sev_pkg::ST_RUN;
            end
         end
         default: r_next.st = sev_pkg::ST_INIT;
      endcase
      if (r_reg.opc_armed && !pending_ops_i)
      begin
         opc_set = 1'b1;
         r_next.opc_armed = 1'b0;
      end
      // Hold ends once every overlapped operation has finished
      if (r_reg.hold && !pending_ops_i)
      begin
         r_next.hold = 1'b0;
      end
      evl_set = '0;
      evl_set[sev_pkg::EL_PON] = (r_reg.st == sev_pkg::ST_INIT);
      evl_set[sev_pkg::EL_URQ] = evt_i.local_key;
      evl_set[sev_pkg::EL_CME] = evt_i.cmd_err;
      evl_set[sev_pkg::EL_EXE] = evt_i.exec_err;
      evl_set[sev_pkg::EL_DDE] = evt_i.dev_err;
      evl_set[sev_pkg::EL_QYE] = evt_i.query_err;
      evl_set[sev_pkg::EL_RQC] = 1'b0;
      evl_set[sev_pkg::EL_OPC] = opc_set;
      // New events win over a clear in the same cycle
      r_next.evl = (evl_clr ? '0 : r_reg.evl) | evl_set;
      sbyte_set = '0;
      sbyte_set[sev_pkg::SB_OPER] = oper_sum;
      sbyte_set[sev_pkg::SB_ESB] = esb;
      sbyte_set[sev_pkg::SB_MAV] = stat_i.mav;
      sbyte_set[sev_pkg::SB_QUES] = ques_sum;
      sbyte_set[sev_pkg::SB_ERRQ] = stat_i.error_queue_pending;
      sbyte_set[sev_pkg::SB_BUSY] = stat_i.busy;
      sbyte_set[sev_pkg::SB_FAULT] = stat_i.fault;
      r_next.sbyte = (sbyte_clr ? '0 : r_reg.sbyte) | sbyte_set;
      r_next.srq = mss;
      r_next.ready = (r_next.st == sev_pkg::ST_RUN) && !r_next.hold;
   end

   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         r_reg <= '0;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign cmd_ready_o = r_reg.ready;
   assign resp_valid_o = r_reg.resp_valid;
   assign resp_data_o = r_reg.resp_data;
   assign srq_o = r_reg.srq;
   assign manual_mode_o = r_reg.manual;
   assign transient_clear_o = r_reg.tclear;
   assign nv_o = {r_reg.psc, r_reg.sre, r_reg.ese, oper_en, ques_en};

   poll_answer_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      take && cmd_code_i == sev_pkg::CMD_OPC_POLL |=> resp_valid_o &&
      resp_data_o == ($past(pending_ops_i) ? sev_pkg::OPC_PENDING : sev_pkg::OPC_DONE))
      else $error("completion poll answer wrong or late");
   psc_clear_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      r_reg.st == sev_pkg::ST_INIT && nv_i.psc |=> nv_o.sre == '0 && nv_o.ese == '0)
      else $error("masks not cleared at power-up");
   rst_pulse_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      take && cmd_code_i == sev_pkg::CMD_RST |=> manual_mode_o && transient_clear_o
      ##1 !manual_mode_o)
      else $error("reset command pulses wrong");
   sre_write_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      take && cmd_code_i == sev_pkg::CMD_SRE_WR |=> nv_o.sre == $past(cmd_data_i[7:0]))
      else $error("service mask write lost");
   sre_read_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      take && cmd_code_i == sev_pkg::CMD_SRE_RD |=> resp_data_o[7:0] == $past(r_reg.sre)
      && nv_o.sre == '0)
      else $error("service mask read did not return then clear");
   stb_read_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      take && cmd_code_i == sev_pkg::CMD_SB_RD |=> resp_valid_o &&
      resp_data_o[7:0] == $past(sbyte_view))
      else $error("status byte read wrong");
   wai_hold_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      r_reg.hold |-> !cmd_ready_o)
      else $error("commands accepted during wait");
   cls_clear_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      take && cmd_code_i == sev_pkg::CMD_CLS && evl_set == '0 |=> r_reg.evl == '0)
      else $error("clear status left latch bits");
   esb_sets_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      esb |=> r_reg.sbyte[sev_pkg::SB_ESB])
      else $error("event summary not set");
   opc_done_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      r_reg.opc_armed && !pending_ops_i |=> r_reg.evl[sev_pkg::EL_OPC] && !r_reg.opc_armed)
      else $error("completion bit not set");

   blocking_opc_c: cover property (@(posedge clock_i) disable iff (!nrst_i)
      r_reg.st == sev_pkg::ST_OPCWAIT ##[1:20] resp_valid_o);
   wai_release_c: cover property (@(posedge clock_i) disable iff (!nrst_i)
      r_reg.hold ##[1:20] cmd_ready_o);
   srq_raise_c: cover property (@(posedge clock_i) disable iff (!nrst_i)
      !srq_o ##1 srq_o);
endmodule

// [dv/sev_host_model.sv]
`timescale 1ns/1ns
module sev_host_model #(
   parameter int RST_GAP = 8
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic go_i,
   input wire sev_pkg::sev_cmd_type code_i,
   input wire logic [sev_pkg::DATA_W-1:0] data_i,
   input wire logic cmd_ready_i,
   output logic cmd_valid_o,
   output sev_pkg::sev_cmd_type cmd_code_o,
   output logic [sev_pkg::DATA_W-1:0] cmd_data_o,
   output logic busy_o
);
   logic [7:0] gap_reg;
   assign busy_o = cmd_valid_o || go_i || (gap_reg != 8'h00);
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cmd_valid_o <= 1'b0;
         cmd_code_o <= sev_pkg::CMD_NOP;
         cmd_data_o <= 16'h0000;
         gap_reg <= 8'h00;
      end
      else if (cmd_valid_o)
      begin
         if (cmd_ready_i)
         begin
            cmd_valid_o <= 1'b0;
            cmd_data_o <= ~cmd_data_o;
            if (cmd_code_o == sev_pkg::CMD_RST)
               gap_reg <= 8'(RST_GAP);
         end
      end
      else if (gap_reg != 8'h00)
         gap_reg <= gap_reg - 8'h01;
      else if (go_i)
      begin
         cmd_valid_o <= 1'b1;
         cmd_code_o <= code_i;
         cmd_data_o <= data_i;
      end
   end
endmodule

// [dv/tb_sev_status.sv]
`timescale 1ns/1ns
module tb_sev_status;
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic cmd_valid, go = 1'b0, busy, pending_ops_i = 1'b0, srq_o, cmd_ready_o, resp_valid_o;
   logic manual_mode_o, transient_clear_o;
   sev_pkg::sev_cmd_type cmd_code, code = sev_pkg::CMD_NOP;
   logic [15:0] cmd_data, data = 16'h0000, resp_data_o, en, c;
   logic [15:0] oper_cond_i = 16'h0000, ques_cond_i = 16'h0000;
   sev_pkg::sev_evt_type evt_i = '0;
   sev_pkg::sev_stat_type stat_i = '0;
   sev_pkg::sev_nv_type nv_i = '0, nv_o;
   logic [15:0] exp_q[$];
   logic [7:0] rq_mask_v, ev_mask_v;
   logic [4:0] ev;
   logic [3:0] st;
   int err_total = 0, samples_checked = 0, cyc = 0, man_n = 0, tr_n = 0;
   sev_pkg::sev_cmd_type gc[2][4] = '{
      '{sev_pkg::CMD_OPER_EN_WR, sev_pkg::CMD_OPER_COND_RD, sev_pkg::CMD_OPER_EVT_RD,
        sev_pkg::CMD_OPER_EN_RD},
      '{sev_pkg::CMD_QUES_EN_WR, sev_pkg::CMD_QUES_COND_RD, sev_pkg::CMD_QUES_EVT_RD,
        sev_pkg::CMD_QUES_EN_RD}};

   sev_status u_sev_status (.clock_i(clock_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid),
      .cmd_code_i(cmd_code), .cmd_data_i(cmd_data), .evt_i(evt_i), .stat_i(stat_i),
      .pending_ops_i(pending_ops_i), .oper_cond_i(oper_cond_i), .ques_cond_i(ques_cond_i),
      .nv_i(nv_i), .cmd_ready_o(cmd_ready_o), .resp_valid_o(resp_valid_o),
      .resp_data_o(resp_data_o), .srq_o(srq_o), .manual_mode_o(manual_mode_o),
      .transient_clear_o(transient_clear_o), .nv_o(nv_o));
   sev_host_model u_sev_host_model (.clock_i(clock_i), .nrst_i(nrst_i), .go_i(go),
      .code_i(code), .data_i(data), .cmd_ready_i(cmd_ready_o), .cmd_valid_o(cmd_valid),
      .cmd_code_o(cmd_code), .cmd_data_o(cmd_data), .busy_o(busy));

   initial
   begin
      forever #2 clock_i = ~clock_i;
   end

   task automatic finish_test();
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask

   task automatic send(input sev_pkg::sev_cmd_type cd, input logic [15:0] d);
      @(negedge clock_i);
      while (busy !== 1'b0) @(negedge clock_i);
      @(posedge clock_i);
      go <= 1'b1;
      code <= cd;
      data <= d;
      @(posedge clock_i);
      go <= 1'b0;
   endtask

   task automatic query(input sev_pkg::sev_cmd_type cd, input logic [15:0] exp);
      exp_q.push_back(exp);
      send(cd, 16'h0000);
   endtask

   task automatic drain();
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 100)
      begin
         @(posedge clock_i);
         n++;
      end
      check(16'(exp_q.size()), 16'h0000);
   endtask

   task automatic do_reset(input logic psc);
      nv_i.psc <= psc;
      nrst_i <= 1'b0;
      wait_cyc(4);
      nrst_i <= 1'b1;
      wait_cyc(2);
   endtask

   always @(negedge clock_i)
   begin
      if (resp_valid_o === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(resp_data_o, ~resp_data_o);
         else
            check(resp_data_o, exp_q.pop_front());
      end
      if (manual_mode_o === 1'b1)
         man_n++;
      if (transient_clear_o === 1'b1)
         tr_n++;
   end

   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         finish_test();
      end
   end

   initial
   begin
      void'($urandom(93));
      rq_mask_v = 8'($urandom) & 8'hBF;
      ev_mask_v = 8'($urandom);
      nv_i.sre = rq_mask_v;
      nv_i.ese = ev_mask_v;
      do_reset(1'b0);
      query(sev_pkg::CMD_EVL_RD, 16'h0080);
      query(sev_pkg::CMD_EVL_RD, 16'h0000);
      query(sev_pkg::CMD_ESE_RD, {8'h00, ev_mask_v});
      query(sev_pkg::CMD_SRE_RD, {8'h00, rq_mask_v});
      query(sev_pkg::CMD_SRE_RD, 16'h0000);
      drain();
      do_reset(1'b1);
      query(sev_pkg::CMD_ESE_RD, 16'h0000);
      query(sev_pkg::CMD_SRE_RD, 16'h0000);
      query(sev_pkg::CMD_EVL_RD, 16'h0080);
      drain();
      ev = 5'($urandom);
      evt_i <= sev_pkg::sev_evt_type'(ev);
      @(posedge clock_i);
      evt_i <= '0;
      query(sev_pkg::CMD_EVL_RD, {8'h00, 1'b0, ev[0], ev[4:1], 2'b00});
      send(sev_pkg::CMD_SRE_WR, 16'h00BF);
      send(sev_pkg::CMD_ESE_WR, 16'h0020);
      wait_cyc(4);
      check({8'h00, nv_o.sre}, 16'h00BF);
      evt_i.cmd_err <= 1'b1;
      @(posedge clock_i);
      evt_i <= '0;
      wait_cyc(4);
      check({15'h0000, srq_o}, 16'h0001);
      query(sev_pkg::CMD_EVL_RD, 16'h0020);
      query(sev_pkg::CMD_SB_RD, 16'h0060);
      query(sev_pkg::CMD_SB_RD, 16'h0000);
      drain();
      st = 4'($urandom) | 4'h1;
      stat_i <= sev_pkg::sev_stat_type'(st);
      wait_cyc(4);
      query(sev_pkg::CMD_SB_RD, {8'h00, 3'b010, st[3], 1'b0, st[2:0]});
      drain();
      stat_i <= sev_pkg::sev_stat_type'(4'h1);
      send(sev_pkg::CMD_SRE_WR, 16'h0040);
      wait_cyc(4);
      check({15'h0000, srq_o}, 16'h0000);
      send(sev_pkg::CMD_SRE_WR, 16'h0001);
      wait_cyc(4);
      check({15'h0000, srq_o}, 16'h0001);
      stat_i <= '0;
      send(sev_pkg::CMD_SRE_WR, 16'h00BF);
      for (int g = 0; g < 2; g++)
      begin
         en = 16'($urandom);
         c = 16'($urandom) | 16'h0001;
         send(gc[g][0], en);
         send(sev_pkg::CMD_CLS, 16'h0000);
         wait_cyc(3);
         query(sev_pkg::CMD_SB_RD, 16'h0000);
         drain();
         if (g == 0)
            oper_cond_i <= c;
         else
            ques_cond_i <= c;
         wait_cyc(4);
         query(gc[g][1], c);
         query(sev_pkg::CMD_SB_RD,
            (|(en & c)) ? (g == 0 ? 16'h00C0 : 16'h0048) : 16'h0000);
         drain();
         oper_cond_i <= 16'h0000;
         ques_cond_i <= 16'h0000;
         wait_cyc(2);
         query(gc[g][2], c);
         query(gc[g][2], 16'h0000);
         query(gc[g][3], en);
         drain();
      end
      pending_ops_i <= 1'b1;
      query(sev_pkg::CMD_OPC_POLL, sev_pkg::OPC_PENDING);
      drain();
      pending_ops_i <= 1'b0;
      query(sev_pkg::CMD_OPC_POLL, sev_pkg::OPC_DONE);
      send(sev_pkg::CMD_CLS, 16'h0000);
      pending_ops_i <= 1'b1;
      send(sev_pkg::CMD_OPC, 16'h0000);
      wait_cyc(6);
      query(sev_pkg::CMD_EVL_RD, 16'h0000);
      drain();
      pending_ops_i <= 1'b0;
      wait_cyc(4);
      query(sev_pkg::CMD_EVL_RD, 16'h0001);
      drain();
      pending_ops_i <= 1'b1;
      send(sev_pkg::CMD_WAI, 16'h0000);
      query(sev_pkg::CMD_EVL_RD, 16'h0000);
      wait_cyc(8);
      check({15'h0000, cmd_ready_o}, 16'h0000);
      check(16'(exp_q.size()), 16'h0001);
      pending_ops_i <= 1'b0;
      drain();
      pending_ops_i <= 1'b1;
      query(sev_pkg::CMD_OPC_BLOCK, sev_pkg::OPC_DONE);
      wait_cyc(6);
      check({15'h0000, cmd_ready_o}, 16'h0000);
      check(16'(exp_q.size()), 16'h0001);
      pending_ops_i <= 1'b0;
      drain();
      send(sev_pkg::CMD_RST, 16'h0000);
      query(sev_pkg::CMD_ESE_RD, 16'h0020);
      drain();
      check(16'(man_n), 16'h0001);
      check(16'(tr_n), 16'h0001);
      send(sev_pkg::CMD_PSC_WR, 16'h0000);
      query(sev_pkg::CMD_PSC_RD, 16'h0000);
      drain();
      check({15'h0000, nv_o.psc}, 16'h0000);
      finish_test();
   end
endmodule
